// ### exec_pkg.sv
`default_nettype none

package exec_pkg;

    // Positions of the flags inside the status flags register.
    localparam logic [2:0] flag_c_pos = 3'h0;
    localparam logic [2:0] flag_z_pos = 3'h1;
    localparam logic [2:0] flag_n_pos = 3'h2;
    localparam logic [2:0] flag_v_pos = 3'h3;
    localparam logic [2:0] flag_s_pos = 3'h4;
    localparam logic [2:0] flag_h_pos = 3'h5;
    localparam logic [2:0] flag_t_pos = 3'h6;
    localparam logic [2:0] flag_i_pos = 3'h7;

    localparam logic [7:0] status_flags_reset = 8'h00;
    localparam logic [15:0] pointer_step = 16'h0001;

    typedef enum logic [5:0] {
        op_nop                   = 6'b000000,
        op_arith_right_shift     = 6'b000001,
        op_swap_nibbles          = 6'b000010,
        op_flag_bit_set          = 6'b000011,
        op_flag_bit_clear        = 6'b000100,
        op_bit_to_tflag          = 6'b000101,
        op_tflag_to_bit          = 6'b000110,
        op_overflow_set          = 6'b000111,
        op_overflow_clear        = 6'b001000,
        op_halfcarry_set         = 6'b001001,
        op_halfcarry_clear       = 6'b001010,
        op_sign_set              = 6'b001011,
        op_sign_clear            = 6'b001100,
        op_carry_set             = 6'b001101,
        op_carry_clear           = 6'b001110,
        op_negative_set          = 6'b001111,
        op_negative_clear        = 6'b010000,
        op_zero_set              = 6'b010001,
        op_zero_clear            = 6'b010010,
        op_tflag_set             = 6'b010011,
        op_tflag_clear           = 6'b010100,
        op_int_enable            = 6'b010101,
        op_int_disable           = 6'b010110,
        op_copy_register         = 6'b010111,
        op_copy_register_pair    = 6'b011000,
        op_load_immediate        = 6'b011001,
        op_load_via_pointer      = 6'b011010,
        op_load_post_inc         = 6'b011011,
        op_load_pre_dec          = 6'b011100,
        op_load_pointer_offset   = 6'b011101,
        op_load_direct_address   = 6'b011110,
        op_write_via_pointer     = 6'b011111,
        op_write_post_inc        = 6'b100000,
        op_write_pre_dec         = 6'b100001,
        op_write_pointer_offset  = 6'b100010,
        op_write_direct_address  = 6'b100011
    } op_type;

    typedef enum logic [1:0] {
        ptr_x = 2'b00,
        ptr_y = 2'b01,
        ptr_z = 2'b10
    } ptr_sel_type;

    typedef struct packed {
        logic [4:0] dst_index;
        logic [2:0] bit_index;
        ptr_sel_type ptr_sel;
        logic [5:0] disp;
        logic [7:0] imm;
        logic [15:0] addr;
    } instr_fields_type;

    typedef struct packed {
        logic [7:0] dst_value;
        logic [7:0] src_value;
        logic [7:0] src_hi_value;
        logic [15:0] ptr_value;
    } operands_type;

    typedef struct packed {
        logic write;
        logic pair;
        logic [4:0] index;
        logic [7:0] lo;
        logic [7:0] hi;
    } reg_write_type;

    typedef struct packed {
        logic write;
        ptr_sel_type sel;
        logic [15:0] value;
    } ptr_write_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_type;

    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] i,
                                           input logic b);
        logic [7:0] r;
        r = v;
        r[i] = b;
        return r;
    endfunction

endpackage

`default_nettype wire

// ### bit_flag_unit.sv
`timescale 1ns/100ps
`default_nettype none

module bit_flag_unit (
    input wire exec_pkg::op_type op,
    input wire logic [2:0] bit_index,
    input wire logic [7:0] dst_value,
    input wire logic [7:0] src_value,
    input wire logic [7:0] flags_in,
    output logic is_bit_op,
    output logic result_write,
    output logic [7:0] result,
    output logic [7:0] flags_out
);

    logic [7:0] shifted;

    always_comb begin
        shifted = {dst_value[7], dst_value[7:1]};
        is_bit_op = 1'b1;
        result_write = 1'b0;
        result = dst_value;
        flags_out = flags_in;
        case (op)
            exec_pkg::op_arith_right_shift: begin
                result_write = 1'b1;
                result = shifted;
                flags_out = exec_pkg::put_bit(flags_out, exec_pkg::flag_c_pos, dst_value[0]);
                flags_out = exec_pkg::put_bit(flags_out, exec_pkg::flag_z_pos,
                                              shifted == 8'h00);
                flags_out = exec_pkg::put_bit(flags_out, exec_pkg::flag_n_pos, shifted[7]);
                flags_out = exec_pkg::put_bit(flags_out, exec_pkg::flag_v_pos,
                                              shifted[7] ^ dst_value[0]);
            end
            exec_pkg::op_swap_nibbles: begin
                result_write = 1'b1;
                result = {dst_value[3:0], dst_value[7:4]};
            end
            exec_pkg::op_bit_to_tflag: begin
                flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_t_pos,
                                              src_value[bit_index]);
            end
            exec_pkg::op_tflag_to_bit: begin
                result_write = 1'b1;
                result = exec_pkg::put_bit(dst_value, bit_index,
                                           flags_in[exec_pkg::flag_t_pos]);
            end
            exec_pkg::op_flag_bit_set: flags_out = exec_pkg::put_bit(flags_in, bit_index, 1'b1);
            exec_pkg::op_flag_bit_clear: flags_out = exec_pkg::put_bit(flags_in, bit_index, 1'b0);
            exec_pkg::op_overflow_set: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_v_pos, 1'b1);
            exec_pkg::op_overflow_clear: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_v_pos, 1'b0);
            exec_pkg::op_halfcarry_set: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_h_pos, 1'b1);
            exec_pkg::op_halfcarry_clear: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_h_pos, 1'b0);
            exec_pkg::op_sign_set: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_s_pos, 1'b1);
            exec_pkg::op_sign_clear: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_s_pos, 1'b0);
            exec_pkg::op_carry_set: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_c_pos, 1'b1);
            exec_pkg::op_carry_clear: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_c_pos, 1'b0);
            exec_pkg::op_negative_set: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_n_pos, 1'b1);
            exec_pkg::op_negative_clear: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_n_pos, 1'b0);
            exec_pkg::op_zero_set: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_z_pos, 1'b1);
            exec_pkg::op_zero_clear: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_z_pos, 1'b0);
            exec_pkg::op_tflag_set: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_t_pos, 1'b1);
            exec_pkg::op_tflag_clear: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_t_pos, 1'b0);
            exec_pkg::op_int_enable: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_i_pos, 1'b1);
            exec_pkg::op_int_disable: flags_out = exec_pkg::put_bit(flags_in, exec_pkg::flag_i_pos, 1'b0);
            default: is_bit_op = 1'b0;
        endcase
    end

endmodule // bit_flag_unit

`default_nettype wire

// ### exec_unit.sv
// How it works
// - Arithmetic right shift keeps bit seven, sets Z C N V, one clock.
// - Bit-to-T copies the chosen source bit into T only, one clock.
// - T-to-bit copies T into the chosen destination bit, flags untouched, one clock.
// - Overflow set and clear touch only V, one clock.
// - Half carry set and clear touch only H, one clock.
// - Signed test set and clear touch only S, one clock.
// - Pointer load, plain or post-increment, reads at pointer; increment after; two clocks.
// - Pre-decrement load lowers the pointer first, reads the new address, two clocks.
// - Displaced load reads Y or Z plus displacement, pointer kept, two clocks.
// - Direct load reads the absolute address into the destination, two clocks.
// - Pointer store, plain or post-increment, writes at pointer; increment after; two clocks.
// - Pre-decrement store lowers the pointer first, writes the new address, two clocks.
// - Displaced store writes Y or Z plus displacement, pointer kept, two clocks.
`timescale 1ns/100ps
`default_nettype none

module exec_unit (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic issue,
    input wire exec_pkg::op_type op,
    input wire exec_pkg::instr_fields_type fields,
    input wire exec_pkg::operands_type operands,
    input wire logic [7:0] mem_rdata,
    input wire logic flags_load,
    input wire logic [7:0] flags_load_value,
    output logic ready,
    output logic busy,
    output logic done_r,
    output logic illegal_r,
    output logic [7:0] status_flags_register_r,
    output exec_pkg::reg_write_type reg_write_r,
    output exec_pkg::ptr_write_type ptr_write_r,
    output exec_pkg::mem_req_type mem_req_r
);

    typedef enum logic {
        st_idle   = 1'b0,
        st_access = 1'b1
    } state_type;

    state_type state_r;
    state_type state_nxt;
    logic [7:0] status_flags_register_nxt;
    logic done_nxt;
    logic illegal_nxt;
    exec_pkg::reg_write_type reg_write_nxt;
    exec_pkg::ptr_write_type ptr_write_nxt;
    exec_pkg::mem_req_type mem_req_nxt;

    // What the second clock of a memory access still has to do.
    logic pend_load_r;
    logic pend_load_nxt;
    logic [4:0] pend_index_r;
    logic [4:0] pend_index_nxt;
    exec_pkg::ptr_write_type pend_ptr_r;
    exec_pkg::ptr_write_type pend_ptr_nxt;

    logic unit_is_bit_op;
    logic unit_result_write;
    logic [7:0] unit_result;
    logic [7:0] unit_flags;
    logic [15:0] ptr_inc;
    logic [15:0] ptr_dec;
    logic [15:0] ptr_disp;
    logic accept;

    bit_flag_unit u_bit_flag_unit (
        .op(op),
        .bit_index(fields.bit_index),
        .dst_value(operands.dst_value),
        .src_value(operands.src_value),
        .flags_in(status_flags_register_r),
        .is_bit_op(unit_is_bit_op),
        .result_write(unit_result_write),
        .result(unit_result),
        .flags_out(unit_flags)
    );

    assign ready = (state_r == st_idle);
    assign busy = (state_r == st_access);
    // A request offered while the access is in its second clock is dropped, not queued.
    assign accept = issue && ready;

    assign ptr_inc = operands.ptr_value + exec_pkg::pointer_step;
    assign ptr_dec = operands.ptr_value - exec_pkg::pointer_step;
    assign ptr_disp = operands.ptr_value + {10'h000, fields.disp};

    always_comb begin
        state_nxt = state_r;
        status_flags_register_nxt = status_flags_register_r;
        done_nxt = 1'b0;
        illegal_nxt = 1'b0;
        reg_write_nxt = '0;
        ptr_write_nxt = '0;
        mem_req_nxt = '0;
        pend_load_nxt = pend_load_r;
        pend_index_nxt = pend_index_r;
        pend_ptr_nxt = pend_ptr_r;

        // Another execution unit may load the flags; an own flag operation takes precedence.
        if (flags_load) begin
            status_flags_register_nxt = flags_load_value;
        end

        case (state_r)
            st_idle: begin
                if (accept) begin
                    pend_index_nxt = fields.dst_index;
                    pend_ptr_nxt = '0;
                    pend_ptr_nxt.sel = fields.ptr_sel;
                    pend_load_nxt = 1'b0;
                    mem_req_nxt.wdata = operands.src_value;
                    if (unit_is_bit_op) begin
                        status_flags_register_nxt = unit_flags;
                        reg_write_nxt.write = unit_result_write;
                        reg_write_nxt.index = fields.dst_index;
                        reg_write_nxt.lo = unit_result;
                        done_nxt = 1'b1;
                    end else begin
                        case (op)
                            exec_pkg::op_copy_register: begin
                                reg_write_nxt.write = 1'b1;
                                reg_write_nxt.index = fields.dst_index;
                                reg_write_nxt.lo = operands.src_value;
                                done_nxt = 1'b1;
                            end
                            exec_pkg::op_copy_register_pair: begin
                                // The pair always starts on an even register.
                                reg_write_nxt.write = 1'b1;
                                reg_write_nxt.pair = 1'b1;
                                reg_write_nxt.index = {fields.dst_index[4:1], 1'b0};
                                reg_write_nxt.lo = operands.src_value;
                                reg_write_nxt.hi = operands.src_hi_value;
                                done_nxt = 1'b1;
                            end
                            exec_pkg::op_load_immediate: begin
                                reg_write_nxt.write = 1'b1;
                                reg_write_nxt.index = fields.dst_index;
                                reg_write_nxt.lo = fields.imm;
                                done_nxt = 1'b1;
                            end
                            exec_pkg::op_load_via_pointer: begin
                                mem_req_nxt.read = 1'b1;
                                mem_req_nxt.addr = operands.ptr_value;
                                pend_load_nxt = 1'b1;
                                state_nxt = st_access;
                            end
                            exec_pkg::op_load_post_inc: begin
                                mem_req_nxt.read = 1'b1;
                                mem_req_nxt.addr = operands.ptr_value;
                                pend_ptr_nxt.write = 1'b1;
                                pend_ptr_nxt.value = ptr_inc;
                                pend_load_nxt = 1'b1;
                                state_nxt = st_access;
                            end
                            exec_pkg::op_load_pre_dec: begin
                                mem_req_nxt.read = 1'b1;
                                mem_req_nxt.addr = ptr_dec;
                                pend_ptr_nxt.write = 1'b1;
                                pend_ptr_nxt.value = ptr_dec;
                                pend_load_nxt = 1'b1;
                                state_nxt = st_access;
                            end
                            exec_pkg::op_load_pointer_offset: begin
                                if (fields.ptr_sel == exec_pkg::ptr_y ||
                                    fields.ptr_sel == exec_pkg::ptr_z) begin
                                    mem_req_nxt.read = 1'b1;
                                    mem_req_nxt.addr = ptr_disp;
                                    pend_load_nxt = 1'b1;
                                    state_nxt = st_access;
                                end else begin
                                    illegal_nxt = 1'b1;
                                    done_nxt = 1'b1;
                                end
                            end
                            exec_pkg::op_load_direct_address: begin
                                mem_req_nxt.read = 1'b1;
                                mem_req_nxt.addr = fields.addr;
                                pend_load_nxt = 1'b1;
                                state_nxt = st_access;
                            end
                            exec_pkg::op_write_via_pointer: begin
                                mem_req_nxt.write = 1'b1;
                                mem_req_nxt.addr = operands.ptr_value;
                                state_nxt = st_access;
                            end
                            exec_pkg::op_write_post_inc: begin
                                mem_req_nxt.write = 1'b1;
                                mem_req_nxt.addr = operands.ptr_value;
                                pend_ptr_nxt.write = 1'b1;
                                pend_ptr_nxt.value = ptr_inc;
                                state_nxt = st_access;
                            end
                            exec_pkg::op_write_pre_dec: begin
                                mem_req_nxt.write = 1'b1;
                                mem_req_nxt.addr = ptr_dec;
                                pend_ptr_nxt.write = 1'b1;
                                pend_ptr_nxt.value = ptr_dec;
                                state_nxt = st_access;
                            end
                            exec_pkg::op_write_pointer_offset: begin
                                if (fields.ptr_sel == exec_pkg::ptr_y ||
                                    fields.ptr_sel == exec_pkg::ptr_z) begin
                                    mem_req_nxt.write = 1'b1;
                                    mem_req_nxt.addr = ptr_disp;
                                    state_nxt = st_access;
                                end else begin
                                    illegal_nxt = 1'b1;
                                    done_nxt = 1'b1;
                                end
                            end
                            exec_pkg::op_write_direct_address: begin
                                mem_req_nxt.write = 1'b1;
                                mem_req_nxt.addr = fields.addr;
                                state_nxt = st_access;
                            end
                            default: begin
                                done_nxt = 1'b1;
                            end
                        endcase
                    end
                end
            end
            st_access: begin
                // The memory answers during the cycle in which the request stands.
                reg_write_nxt.write = pend_load_r;
                reg_write_nxt.index = pend_index_r;
                reg_write_nxt.lo = mem_rdata;
                ptr_write_nxt = pend_ptr_r;
                done_nxt = 1'b1;
                state_nxt = st_idle;
            end
            default: begin
                state_nxt = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= st_idle;
            status_flags_register_r <= exec_pkg::status_flags_reset;
            done_r <= 1'b0;
            illegal_r <= 1'b0;
            reg_write_r <= '0;
            ptr_write_r <= '0;
            mem_req_r <= '0;
            pend_load_r <= 1'b0;
            pend_index_r <= 5'h00;
            pend_ptr_r <= '0;
        end else begin
            state_r <= state_nxt;
            status_flags_register_r <= status_flags_register_nxt;
            done_r <= done_nxt;
            illegal_r <= illegal_nxt;
            reg_write_r <= reg_write_nxt;
            ptr_write_r <= ptr_write_nxt;
            mem_req_r <= mem_req_nxt;
            pend_load_r <= pend_load_nxt;
            pend_index_r <= pend_index_nxt;
            pend_ptr_r <= pend_ptr_nxt;
        end
    end

endmodule // exec_unit

`default_nettype wire

// ### exec_unit_properties.sv
`timescale 1ns/100ps
`default_nettype none
module exec_unit_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic issue,
    input wire exec_pkg::op_type op,
    input wire exec_pkg::operands_type operands,
    input wire logic [7:0] mem_rdata,
    input wire logic flags_load,
    input wire logic ready,
    input wire logic busy,
    input wire logic done_r,
    input wire logic [7:0] status_flags_register_r,
    input wire exec_pkg::reg_write_type reg_write_r,
    input wire exec_pkg::ptr_write_type ptr_write_r,
    input wire exec_pkg::mem_req_type mem_req_r
);
    logic go;
    logic [7:0] sf;
    // An outside flag write in the same cycle would blur the flag relations, so it is left out.
    assign go = issue && ready && !flags_load;
    assign sf = status_flags_register_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    asr_result_a: assert property (go && op == exec_pkg::op_arith_right_shift |=>
        reg_write_r.write && reg_write_r.lo == {$past(operands.dst_value[7]),
        $past(operands.dst_value[7:1])}) else $error("shift result wrong");
    tflag_only_a: assert property (go && op == exec_pkg::op_bit_to_tflag |=>
        done_r && ((sf ^ $past(sf)) & 8'hbf) == 8'h00) else $error("bit copy touched flags");
    tbit_flags_a: assert property (go && op == exec_pkg::op_tflag_to_bit |=>
        done_r && reg_write_r.write && $stable(sf)) else $error("bit load wrong");
    v_set_a: assert property (go && op == exec_pkg::op_overflow_set |=>
        sf == ($past(sf) | 8'h08)) else $error("overflow set wrong");
    h_clear_a: assert property (go && op == exec_pkg::op_halfcarry_clear |=>
        sf == ($past(sf) & 8'hdf)) else $error("half carry clear wrong");
    s_set_a: assert property (go && op == exec_pkg::op_sign_set |=>
        sf == ($past(sf) | 8'h10)) else $error("sign set wrong");
    predec_load_a: assert property (go && op == exec_pkg::op_load_pre_dec |=>
        busy && mem_req_r.read && mem_req_r.addr == $past(operands.ptr_value) - 16'h0001
        ##1 done_r && ptr_write_r.value == $past(operands.ptr_value, 2) - 16'h0001)
        else $error("pre-decrement load wrong");
    direct_load_a: assert property (go && op == exec_pkg::op_load_direct_address |=>
        mem_req_r.read && !done_r ##1 done_r && reg_write_r.lo == $past(mem_rdata))
        else $error("direct load wrong");
    postinc_store_a: assert property (go && op == exec_pkg::op_write_post_inc |=>
        mem_req_r.write && !done_r ##1 done_r && ptr_write_r.write
        && ptr_write_r.value == $past(operands.ptr_value, 2) + 16'h0001)
        else $error("post-increment store wrong");
    copy_flags_a: assert property (go && op inside {exec_pkg::op_swap_nibbles,
        exec_pkg::op_copy_register, exec_pkg::op_copy_register_pair,
        exec_pkg::op_load_immediate} |=> done_r && $stable(sf)) else $error("copy moved flags");
endmodule // exec_unit_properties
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clock = 1'b0, rst_n = 1'b0, issue = 1'b0, flags_load = 1'b0;
    exec_pkg::op_type op = exec_pkg::op_nop;
    exec_pkg::instr_fields_type fields = '0;
    exec_pkg::operands_type operands = '0;
    logic [7:0] mem_rdata = 8'h00, flags_load_value = 8'h00, flg = exec_pkg::status_flags_reset;
    logic ready, busy, done_r, illegal_r;
    logic [7:0] status_flags_register_r;
    exec_pkg::reg_write_type reg_write_r;
    exec_pkg::ptr_write_type ptr_write_r;
    exec_pkg::mem_req_type mem_req_r;
    logic [31:0] seed = 32'h24;
    logic [34:0] notes [$];
    int n_errors = 0, comparisons = 0;
    logic [2:0] pos [8] = '{3'h3, 3'h5, 3'h4, 3'h0, 3'h2, 3'h1, 3'h6, 3'h7};
    always #2.5 clock = ~clock;
    exec_unit exec_unit_inst (.clock, .rst_n, .issue, .op, .fields, .operands, .mem_rdata,
        .flags_load, .flags_load_value, .ready, .busy, .done_r, .illegal_r,
        .status_flags_register_r, .reg_write_r, .ptr_write_r, .mem_req_r);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string nm, logic [34:0] e, logic [34:0] g);
        comparisons++;
        if (e !== g) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic ld_flags();
        issue = 1'b0;
        flags_load = 1'b1;
        flags_load_value = 8'(rnd());
        flg = flags_load_value;
        @(negedge clock);
        flags_load = 1'b0;
    endtask
    task automatic iss(exec_pkg::op_type o);
        logic [7:0] d, s, lo;
        logic [15:0] p, a, pv;
        logic wr, pw, il, ld, pr;
        logic [5:0] k;
        {fields, operands, mem_rdata, flags_load_value} = {rnd(), rnd(), rnd()};
        if (fields.ptr_sel == 2'h3) fields.ptr_sel = exec_pkg::ptr_z;
        {d, s, p} = {operands.dst_value, operands.src_value, operands.ptr_value};
        op = o;
        issue = 1'b1;
        {wr, pw, il, lo, pv, a, k} = {3'h0, d, 16'h0000, p, o - 6'h07};
        case (o)
            exec_pkg::op_arith_right_shift: begin
                lo = {d[7], d[7:1]};
                wr = 1'b1;
                flg[3:0] = {lo[7] ^ d[0], lo[7], lo == 8'h00, d[0]};
            end
            exec_pkg::op_swap_nibbles: {wr, lo} = {1'b1, d[3:0], d[7:4]};
            exec_pkg::op_flag_bit_set, exec_pkg::op_flag_bit_clear:
                flg[fields.bit_index] = o == exec_pkg::op_flag_bit_set;
            exec_pkg::op_bit_to_tflag: flg[6] = s[fields.bit_index];
            exec_pkg::op_tflag_to_bit: {wr, lo[fields.bit_index]} = {1'b1, flg[6]};
            exec_pkg::op_copy_register, exec_pkg::op_copy_register_pair: {wr, lo} = {1'b1, s};
            exec_pkg::op_load_immediate: {wr, lo} = {1'b1, fields.imm};
            exec_pkg::op_load_post_inc, exec_pkg::op_write_post_inc:
                {pw, pv} = {1'b1, p + 16'h0001};
            exec_pkg::op_load_pre_dec, exec_pkg::op_write_pre_dec:
                {a, pw, pv} = {p - 16'h0001, 1'b1, p - 16'h0001};
            exec_pkg::op_load_pointer_offset, exec_pkg::op_write_pointer_offset:
                {a, il} = {p + 16'(fields.disp), fields.ptr_sel == exec_pkg::ptr_x};
            exec_pkg::op_load_direct_address, exec_pkg::op_write_direct_address: a = fields.addr;
            default: if (k < 6'h10) flg[pos[k[3:1]]] = !k[0];
        endcase
        ld = o inside {[exec_pkg::op_load_via_pointer:exec_pkg::op_load_direct_address]};
        if (ld) {wr, lo} = {!il, mem_rdata};
        pr = o == exec_pkg::op_copy_register_pair;
        notes.push_back({il, wr, wr ? lo : 8'h00, flg, pw, pw ? pv : 16'h0000});
        @(negedge clock);
        if (wr && !ld) chk("reg_dest", {pr, pr ? {fields.dst_index[4:1], 1'b0} : fields.dst_index,
            pr ? operands.src_hi_value : 8'h00}, {reg_write_r.pair, reg_write_r.index,
            reg_write_r.pair ? reg_write_r.hi : 8'h00});
        if (o >= exec_pkg::op_load_via_pointer) begin
            // A second request while busy must be dropped, so one is offered at random.
            issue = !il && rnd() > 32'h7fffffff;
            chk("mem_req", {il ? 16'h0000 : a, (ld || il) ? 8'h00 : s, !il && ld, !il && !ld},
                {(mem_req_r.read || mem_req_r.write) ? mem_req_r.addr : 16'h0000,
                mem_req_r.write ? mem_req_r.wdata : 8'h00, mem_req_r.read,
                mem_req_r.write});
            chk("busy", !il, busy);
            @(negedge clock);
            if (pw) chk("ptr_sel", fields.ptr_sel, ptr_write_r.sel);
        end
    endtask
    always @(negedge clock) begin
        if (rst_n && done_r === 1'b1) begin
            if (notes.size() == 0) chk("done_r", 35'h0, 35'h1);
            else chk("result", notes.pop_front(), {illegal_r, reg_write_r.write,
                reg_write_r.write ? reg_write_r.lo : 8'h00, status_flags_register_r,
                ptr_write_r.write, ptr_write_r.write ? ptr_write_r.value : 16'h0000});
        end
    end
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++) iss(exec_pkg::op_type'(6'h07 + 6'(i)));
        $display("Test of single flag operations ended");
        repeat (4) begin
            ld_flags();
            repeat (60) iss(exec_pkg::op_type'(6'h01 + 6'(rnd() % 32'h23)));
        end
        $display("Test of random operations ended");
        issue = 1'b0;
        repeat (4) @(negedge clock);
        chk("pending", 35'h0, 35'(notes.size()));
        end_sim();
    end
    initial begin
        #20000;
        n_errors++;
        $display("BAD watchdog exp finish got timeout");
        end_sim();
    end
endmodule // tb
bind exec_unit exec_unit_properties exec_unit_properties_inst (.clock, .rst_n, .issue, .op,
    .operands, .mem_rdata, .flags_load, .ready, .busy, .done_r, .status_flags_register_r,
    .reg_write_r, .ptr_write_r, .mem_req_r);
`default_nettype wire
